// ==== common/mgmt_pkg.sv ====
// constants for the serial management port of the eight-port phy
// assumes a 100 MHz system clock and an APB register bus
package mgmt_pkg;
  localparam int          NUM_PORTS        = 8;
  localparam int          NUM_REGS         = 33;
  localparam logic [11:0] ADDR_CONFIG      = 12'h0_000;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h0_004;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h0_008;
  localparam logic [11:0] ADDR_HW_DEFAULT  = 12'h0_00C;
  localparam logic [11:0] ADDR_EVENT       = 12'h0_010;
  localparam logic [11:0] ADDR_MGMT_STATUS = 12'h0_014;
  localparam int          CFG_SPLIT_BIT    = 0;
  localparam int          CFG_PDOWN_BIT    = 1;
  localparam logic [1:0]  CONFIG_RESET     = 2'h0;
  localparam logic [3:0]  IRQ_ST_RESET     = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;
  localparam int          IRQ_EN_REG       = 18;
  localparam int          IRQ_EN_BIT       = 1;
  localparam int          STAT_REG         = 1;
  localparam logic [1:0]  OP_WRITE         = 2'b01;
  localparam logic [1:0]  OP_READ          = 2'b10;
  localparam int          PREAMBLE_BITS    = 32;
  localparam int          MDC_MAX_MHZ      = 20;
endpackage

// ==== logic/mgmt_frame_engine.sv ====
// one clause-22 management frame engine for one section of ports
// assumes mdc and mdio already synchronised to clk; the port table lives outside
`timescale 1ns/1ns
module mgmt_frame_engine
  import mgmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic        mdc_rise,
  input  wire logic        mdc_fall,
  input  wire logic        mdio_in,
  input  wire logic [2:0]  port_base,
  input  wire logic [2:0]  port_count,
  output logic             req_valid,
  output logic             req_write,
  output logic [2:0]       req_port,
  output logic [5:0]       req_reg,
  output logic [15:0]      req_wdata,
  input  wire logic [15:0] rd_data,
  output logic             mdio_out,
  output logic             mdio_oe
);
  typedef enum logic [5:0]
  {
    ST_PRE  = 6'b000001,
    ST_HEAD = 6'b000010,
    ST_TA   = 6'b000100,
    ST_RD   = 6'b001000,
    ST_WR   = 6'b010000,
    ST_SKIP = 6'b100000
  } fstate_t;

  fstate_t     state;
  fstate_t     next_state;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic [13:0] sh;
  logic [13:0] next_sh;
  logic [15:0] dsh;
  logic [15:0] next_dsh;
  logic        mine;
  logic        next_mine;
  logic        req_valid_n;
  logic        oe_n;
  logic        out_n;
  logic [4:0]  phy;
  logic [2:0]  rel;
  logic [12:0] hdr;

  // header after the start 0: start 1, op2, phy5, reg5 land in sh[12:0]
  assign phy = sh[9:5];
  assign rel = phy[2:0] - port_base;
  assign hdr = {sh[11:0], mdio_in};

  // =====================================================
  // frame sequencing
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_sh     = sh;
    next_dsh    = dsh;
    next_mine   = mine;
    req_valid_n = 1'b0;
    oe_n        = mdio_oe;
    out_n       = mdio_out;
    if (!enable)
    begin
      next_state = ST_PRE;
      next_cnt   = 6'h0_0;
      oe_n       = 1'b0;
      out_n      = 1'b0;
    end
    else
    begin
      if (mdc_rise)
      begin
        unique case (state)
          ST_PRE:
          begin
            // idle ones then start pattern 01
            if (mdio_in)
              next_cnt = (cnt == 6'h3_F) ? cnt : cnt + 6'h0_1;
            else if (cnt >= 6'(PREAMBLE_BITS))
            begin
              next_state = ST_HEAD;
              next_cnt   = 6'h0_0;
              next_sh    = 14'h0_000;
            end
            else
              next_cnt = 6'h0_0;
          end
          ST_HEAD:
          begin
            next_sh  = {sh[12:0], mdio_in};
            next_cnt = cnt + 6'h0_1;
            if (cnt == 6'd12)
            begin
              next_state = ST_TA;
              next_cnt   = 6'h0_0;
            end
          end
          ST_TA:
          begin
            next_cnt = cnt + 6'h0_1;
            if (cnt == 6'd1)
            begin
              next_cnt   = 6'h0_0;
              next_state = (sh[11:10] == OP_READ) ? ST_RD : ST_WR;
              if (!mine || sh[11:10] != OP_READ)
                next_state = mine ? ST_WR : ST_SKIP;
            end
          end
          ST_RD:
          begin
            next_cnt = cnt + 6'h0_1;
            if (cnt == 6'd15)
            begin
              next_state = ST_PRE;
              next_cnt   = 6'h0_0;
            end
          end
          ST_WR:
          begin
            next_dsh = {dsh[14:0], mdio_in};
            next_cnt = cnt + 6'h0_1;
            if (cnt == 6'd15)
            begin
              next_state  = ST_PRE;
              next_cnt    = 6'h0_0;
              req_valid_n = (sh[11:10] == OP_WRITE);
            end
          end
          ST_SKIP:
          begin
            next_cnt = cnt + 6'h0_1;
            if (cnt == 6'd15)
            begin
              next_state = ST_PRE;
              next_cnt   = 6'h0_0;
            end
          end
          default:
            next_state = ST_PRE;
        endcase
        if (state == ST_HEAD && cnt == 6'd12)
        begin
          // decide address match once the whole header is in
          // port_count 0 stands for all eight ports of a single section
          next_mine = hdr[12] && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE) && hdr[9:8] == 2'b00
                      && (port_count == 3'd0 || (hdr[7:5] >= port_base && hdr[7:5] - port_base < port_count));
        end
      end
      if (state == ST_HEAD && cnt == 6'd0 && mdc_rise)
        req_valid_n = 1'b0;
      // device drives only during read turnaround low bit and data
      if (mdc_fall)
      begin
        if (state == ST_TA && cnt == 6'd1 && mine && sh[11:10] == OP_READ)
        begin
          oe_n  = 1'b1;
          out_n = 1'b0;
        end
        else if (state == ST_RD)
        begin
          oe_n  = 1'b1;
          out_n = dsh[15];
          next_dsh = {dsh[14:0], 1'b0};
        end
        else
        begin
          oe_n  = 1'b0;
          out_n = 1'b0;
        end
      end
      if (mdc_rise && state == ST_TA && cnt == 6'd0 && mine && sh[11:10] == OP_READ)
        next_dsh = rd_data;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= ST_PRE;
      cnt       <= 6'h0_0;
      sh        <= 14'h0_000;
      dsh       <= 16'h0_000;
      mine      <= 1'b0;
      req_valid <= 1'b0;
      mdio_oe   <= 1'b0;
      mdio_out  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      dsh       <= next_dsh;
      mine      <= next_mine;
      req_valid <= req_valid_n;
      mdio_oe   <= oe_n;
      mdio_out  <= out_n;
    end
  end

  // read fetch happens with sh final, so port/reg come straight from sh
  assign req_write = 1'b1;
  assign req_port  = rel + port_base;
  assign req_reg   = {1'b0, sh[4:0]};
  assign req_wdata = dsh;
endmodule

// ==== logic/phy_mgmt_serial_port.sv ====
// top of the management port: apb registers, two sections, interrupts
// assumes mdc/mdio/strap arrive asynchronously; open-drain wiring is outside
`timescale 1ns/1ns
module phy_mgmt_serial_port
  import mgmt_pkg::*;
#(
  parameter int NPORTS = NUM_PORTS,
  parameter int NREGS  = NUM_REGS
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mgmt_clock_first,
  input  wire logic        mgmt_clock_second,
  input  wire logic        mgmt_data_line_first_in,
  output logic             mgmt_data_line_first_out,
  output logic             mgmt_data_line_first_oe,
  input  wire logic        mgmt_data_line_second_in,
  output logic             mgmt_data_line_second_out,
  output logic             mgmt_data_line_second_oe,
  input  wire logic        serial_mgmt_disable_strap,
  output logic             status_irq_n_first_out,
  output logic             status_irq_n_first_oe,
  output logic             status_irq_n_second_out,
  output logic             status_irq_n_second_oe,
  output logic             irq
);
  if (NPORTS != 8 || NREGS < 33 || NREGS > 64)
    $error("phy_mgmt_serial_port: needs 8 ports and 33..64 registers");

  // =====================================================
  // input synchronisers
  logic [1:0] s_c0, s_c1, s_d0, s_d1, s_dis;
  logic       c0_q, c1_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_c0  <= 2'b00;
      s_c1  <= 2'b00;
      s_d0  <= 2'b11;
      s_d1  <= 2'b11;
      c0_q  <= 1'b0;
      c1_q  <= 1'b0;
    end
    else
    begin
      s_c0  <= {s_c0[0], mgmt_clock_first};
      s_c1  <= {s_c1[0], mgmt_clock_second};
      s_d0  <= {s_d0[0], mgmt_data_line_first_in};
      s_d1  <= {s_d1[0], mgmt_data_line_second_in};
      c0_q  <= s_c0[1];
      c1_q  <= s_c1[1];
    end
  end

  // =====================================================
  // strap capture after reset release
  // no reset here, so the pin level is already through both stages at release
  always_ff @(posedge clk)
    s_dis <= {s_dis[0], serial_mgmt_disable_strap};
  logic strap_taken;
  logic disabled;
  logic next_disabled;
  logic next_taken;
  always_comb
  begin
    next_taken    = 1'b1;
    next_disabled = strap_taken ? disabled : s_dis[1];
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_taken <= 1'b0;
      disabled    <= 1'b0;
    end
    else
    begin
      strap_taken <= next_taken;
      disabled    <= next_disabled;
    end
  end

  // =====================================================
  // apb registers
  logic [1:0]  config_r;
  logic [1:0]  next_config;
  logic [3:0]  irq_st;
  logic [3:0]  next_irq_st;
  logic [3:0]  irq_mask;
  logic [3:0]  next_irq_mask;
  logic [15:0] hw_default;
  logic [15:0] next_hw_default;
  logic [7:0]  ev_req;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        split;
  logic        pdown;
  logic        wr_acc;
  logic        rd_acc;
  assign split  = config_r[CFG_SPLIT_BIT];
  assign pdown  = config_r[CFG_PDOWN_BIT];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;              // decoded in setup so data stands with pready

  // =====================================================
  // port register table
  logic [15:0] regs [NPORTS][NREGS];
  logic        link_ok;
  logic        e0_valid, e1_valid;
  logic [2:0]  e0_port, e1_port;
  logic [5:0]  e0_reg, e1_reg;
  logic [15:0] e0_wdata, e1_wdata;
  logic [15:0] e0_rd, e1_rd;
  logic        e0_oe, e0_out, e1_oe, e1_out;
  logic        e0_rise, e0_fall, e1_rise, e1_fall;
  logic        eng1_en;

  function automatic logic [15:0] reg_read(input logic [2:0] p, input logic [5:0] r);
    reg_read = (32'(r) < NREGS) ? regs[p][r] : 16'h0_000;
  endfunction

  function automatic logic addr_bad(input logic wr, input logic [11:0] a);
    addr_bad = !(a == ADDR_CONFIG || a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK || a == ADDR_HW_DEFAULT
                 || a == ADDR_EVENT || (!wr && a == ADDR_MGMT_STATUS));
  endfunction

  assign link_ok = !disabled && !pdown;
  assign e0_rise = s_c0[1] & ~c0_q;
  assign e0_fall = ~s_c0[1] & c0_q;
  assign e1_rise = s_c1[1] & ~c1_q;
  assign e1_fall = ~s_c1[1] & c1_q;
  assign eng1_en = link_ok && split;
  assign e0_rd   = reg_read(e0_port, e0_reg);
  assign e1_rd   = reg_read(e1_port, e1_reg);

  mgmt_frame_engine u_eng0
  (
    .clk        (clk),
    .resetn     (resetn),
    .enable     (link_ok),
    .mdc_rise   (e0_rise),
    .mdc_fall   (e0_fall),
    .mdio_in    (s_d0[1]),
    .port_base  (3'd0),
    .port_count (split ? 3'd4 : 3'd0),
    .req_valid  (e0_valid),
    .req_write  (),
    .req_port   (e0_port),
    .req_reg    (e0_reg),
    .req_wdata  (e0_wdata),
    .rd_data    (e0_rd),
    .mdio_out   (e0_out),
    .mdio_oe    (e0_oe)
  );

  mgmt_frame_engine u_eng1
  (
    .clk        (clk),
    .resetn     (resetn),
    .enable     (eng1_en),
    .mdc_rise   (e1_rise),
    .mdc_fall   (e1_fall),
    .mdio_in    (s_d1[1]),
    .port_base  (3'd4),
    .port_count (3'd4),
    .req_valid  (e1_valid),
    .req_write  (),
    .req_port   (e1_port),
    .req_reg    (e1_reg),
    .req_wdata  (e1_wdata),
    .rd_data    (e1_rd),
    .mdio_out   (e1_out),
    .mdio_oe    (e1_oe)
  );

  // table writes; link owns bits only when the strap is low
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < NPORTS; p++)
        for (int r = 0; r < NREGS; r++)
          regs[p][r] <= 16'h0_000;
    end
    else if (!strap_taken)
    begin
      for (int p = 0; p < NPORTS; p++)
        regs[p][0] <= hw_default;
    end
    else
    begin
      if (e0_valid && 32'(e0_reg) < NREGS)
        regs[e0_port][e0_reg] <= e0_wdata;
      if (e1_valid && 32'(e1_reg) < NREGS)
        regs[e1_port][e1_reg] <= e1_wdata;
      for (int p = 0; p < NPORTS; p++)
        if (ev_req[p])
          regs[p][STAT_REG][2] <= ~regs[p][STAT_REG][2];
    end
  end

  // =====================================================
  // status-change and write-frame interrupts, per section
  logic [3:0] sec_ev;
  logic [1:0] next_pin_low;
  logic [7:0] en_bits;
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
      en_bits[p] = regs[p][IRQ_EN_REG][IRQ_EN_BIT];
  end
  always_comb
  begin
    // event 0/1: section status changes; 2/3: write frames accepted by section 0/1
    sec_ev[0] = |(ev_req[3:0] & en_bits[3:0]) || (!split && |(ev_req[7:4] & en_bits[7:4]));
    sec_ev[1] = split && |(ev_req[7:4] & en_bits[7:4]);
    sec_ev[2] = e0_valid;
    sec_ev[3] = e1_valid;
    next_pin_low = irq_st[1:0];
  end

  // =====================================================
  // register next values
  always_comb
  begin
    next_config     = config_r;
    next_irq_mask   = irq_mask;
    next_hw_default = hw_default;
    next_irq_st     = irq_st;
    next_prdata     = prdata;
    next_pslverr    = psel && !penable && addr_bad(pwrite, paddr);
    ev_req          = 8'h0_0;
    if (wr_acc)
    begin
      unique case (paddr)
        ADDR_CONFIG:     next_config     = pwdata[1:0];
        ADDR_IRQ_STATUS: next_irq_st     = irq_st & ~pwdata[3:0];
        ADDR_IRQ_MASK:   next_irq_mask   = pwdata[3:0];
        ADDR_HW_DEFAULT: next_hw_default = pwdata[15:0];
        ADDR_EVENT:      ev_req          = pwdata[7:0];
        default:         ev_req          = 8'h0_0;
      endcase
    end
    next_irq_st = next_irq_st | sec_ev;                     // set wins over clear
    if (rd_acc)
    begin
      unique case (paddr)
        ADDR_CONFIG:      next_prdata = {30'h0, config_r};
        ADDR_IRQ_STATUS:  next_prdata = {28'h0, irq_st};
        ADDR_IRQ_MASK:    next_prdata = {28'h0, irq_mask};
        ADDR_HW_DEFAULT:  next_prdata = {16'h0, hw_default};
        ADDR_EVENT:       next_prdata = 32'h0_000_0000;
        ADDR_MGMT_STATUS: next_prdata = {28'h0, e1_oe, e0_oe, strap_taken, disabled};
        default:          next_prdata = 32'h0_000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      config_r   <= CONFIG_RESET;
      irq_st     <= IRQ_ST_RESET;
      irq_mask   <= IRQ_MASK_RESET;
      hw_default <= 16'h0_000;
      prdata     <= 32'h0_000_0000;
      pslverr    <= 1'b0;
      pready     <= 1'b0;
      irq        <= 1'b0;
      mgmt_data_line_first_out  <= 1'b0;
      mgmt_data_line_first_oe   <= 1'b0;
      mgmt_data_line_second_out <= 1'b0;
      mgmt_data_line_second_oe  <= 1'b0;
      status_irq_n_first_out    <= 1'b0;
      status_irq_n_first_oe     <= 1'b0;
      status_irq_n_second_out   <= 1'b0;
      status_irq_n_second_oe    <= 1'b0;
    end
    else
    begin
      config_r   <= next_config;
      irq_st     <= next_irq_st;
      irq_mask   <= next_irq_mask;
      hw_default <= next_hw_default;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
      // no wait state: pready rises in the access cycle, answer next edge
      pready     <= psel && !penable;
      irq        <= |(next_irq_st & next_irq_mask);
      // interrupt pins open drain, only ever drive low; data lines drive both levels; all float in power-down
      mgmt_data_line_first_out  <= e0_out;
      mgmt_data_line_first_oe   <= e0_oe && !pdown;
      mgmt_data_line_second_out <= e1_out;
      mgmt_data_line_second_oe  <= e1_oe && !pdown && split;
      status_irq_n_first_out    <= 1'b0;
      status_irq_n_first_oe     <= next_pin_low[0] && !pdown;
      status_irq_n_second_out   <= 1'b0;
      status_irq_n_second_oe    <= next_pin_low[1] && split && !pdown;
    end
  end
endmodule

// ==== tb/mgmt_port_sva.sv ====
// checker for the management port top: bus handshake, link pins, interrupt pins
// assumes one clk domain and a bind onto the top module
`timescale 1ns/1ns
module mgmt_port_sva
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mgmt_clock_first,
  input wire logic mgmt_data_line_first_out,
  input wire logic mgmt_data_line_first_oe,
  input wire logic mgmt_data_line_second_oe,
  input wire logic serial_mgmt_disable_strap,
  input wire logic status_irq_n_first_out,
  input wire logic status_irq_n_first_oe,
  input wire logic status_irq_n_second_out,
  input wire logic status_irq_n_second_oe,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========
  // register bus
  ready_on_time_a: assert property (psel && !penable |=> pready)
    else $error("pready not in second cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ==========
  // pins
  reset_float_a: assert property (!$past(resetn) |->
    !(mgmt_data_line_first_oe || mgmt_data_line_second_oe || status_irq_n_first_oe || status_irq_n_second_oe))
    else $error("pin driven in reset");
  turnaround_low_a: assert property ($rose(mgmt_data_line_first_oe) |-> !mgmt_data_line_first_out)
    else $error("turnaround not low");
  drive_span_a: assert property ($rose(mgmt_data_line_first_oe) |-> mgmt_data_line_first_oe [*8])
    else $error("drive too short");
  drive_start_a: assert property ($rose(mgmt_data_line_first_oe) |-> !mgmt_clock_first)
    else $error("drive begins with clock high");
  drive_end_a: assert property ($fell(mgmt_data_line_first_oe) |-> !mgmt_clock_first)
    else $error("drive ends with clock high");
  data_steady_a: assert property (mgmt_clock_first && mgmt_data_line_first_oe
    && $past(mgmt_data_line_first_oe) |-> $stable(mgmt_data_line_first_out))
    else $error("data moved while clock high");
  open_drain_a: assert property (!status_irq_n_first_out && !status_irq_n_second_out)
    else $error("interrupt pin driven high");
  strap_quiet_a: assert property (serial_mgmt_disable_strap |->
    !mgmt_data_line_first_oe && !mgmt_data_line_second_oe)
    else $error("link answered while disabled");
endmodule

// ==== tb/mdio_master.sv ====
// partner: management master on one clock/data link
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
module mdio_master
  import mgmt_pkg::*;
(
  output logic      mdc,
  output logic      mdo,
  output logic      m_oe,
  input  wire logic mdio
);
  initial
  begin
    mdc  = 1'b0;
    mdo  = 1'b0;
    m_oe = 1'b0;
  end
  // ==========
  // one frame, 160 ns a bit; clock stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f  = {32'hFFFF_FFFF, 2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    #7;
    for (int i = 63; i >= 0; i--)
    begin
      m_oe = (op == OP_WRITE) || (i > 17);
      mdo  = f[i];
      #80 mdc = 1'b1;
      if (i < 16)
        rd[i] = mdio;
      #80 mdc = 1'b0;
    end
    m_oe = 1'b0;
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the management port top
// assumes two master models and pull-ups on every shared pin
`timescale 1ns/1ns
module tb
  import mgmt_pkg::*;
;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  localparam row_t ROWS [6] = '{'{ADDR_IRQ_MASK, 32'h0000_000F, 32'h0000_000F, 1'b0},
    '{ADDR_IRQ_MASK, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{ADDR_CONFIG, 32'h0000_0003, 32'h0000_0003, 1'b0},
    '{ADDR_CONFIG, 32'h0000_0000, 32'h0000_0000, 1'b0}, '{ADDR_MGMT_STATUS, 32'h0000_000F, 32'h0000_0002, 1'b0},
    '{12'h018, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  logic clk = 1'b0, resetn, psel, penable, pwrite, serial_mgmt_disable_strap, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] dump;
  logic mgmt_data_line_first_out, mgmt_data_line_first_oe, mgmt_data_line_second_out, mgmt_data_line_second_oe;
  logic status_irq_n_first_out, status_irq_n_first_oe, status_irq_n_second_out, status_irq_n_second_oe;
  logic m1_o, m1_oe, m2_o, m2_oe;
  wire  mgmt_clock_first, mgmt_clock_second;
  wire  mgmt_data_line_first_in = mgmt_data_line_first_oe ? mgmt_data_line_first_out : (m1_oe ? m1_o : 1'b1);
  wire  mgmt_data_line_second_in = mgmt_data_line_second_oe ? mgmt_data_line_second_out : (m2_oe ? m2_o : 1'b1);
  wire  pin_a = status_irq_n_first_oe ? status_irq_n_first_out : 1'b1;
  wire  pin_b = status_irq_n_second_oe ? status_irq_n_second_out : 1'b1;
  int   err_total = 0;
  int   n_tests = 0;
  always #5 clk = ~clk;
  phy_mgmt_serial_port u_phy_mgmt_serial_port (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mgmt_clock_first, .mgmt_clock_second, .mgmt_data_line_first_in,
    .mgmt_data_line_first_out, .mgmt_data_line_first_oe, .mgmt_data_line_second_in, .mgmt_data_line_second_out,
    .mgmt_data_line_second_oe, .serial_mgmt_disable_strap, .status_irq_n_first_out, .status_irq_n_first_oe,
    .status_irq_n_second_out, .status_irq_n_second_oe, .irq);
  mdio_master u_mdio_master (.mdc(mgmt_clock_first), .mdo(m1_o), .m_oe(m1_oe), .mdio(mgmt_data_line_first_in));
  mdio_master u_mdio_master_2 (.mdc(mgmt_clock_second), .mdo(m2_o), .m_oe(m2_oe), .mdio(mgmt_data_line_second_in));
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
      chk("pready", 0, 1);
    e = pslverr;
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so the next call never re-raises psel in this time step
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk("register", q, x);
  endtask
  // reads compare against d; writes only send it
  task automatic lf(input logic s, input logic [1:0] op, input logic [4:0] p, input logic [4:0] r,
                    input logic [15:0] d);
    logic [15:0] v;
    if (s)
      u_mdio_master_2.frame(op, p, r, d, v);
    else
      u_mdio_master.frame(op, p, r, d, v);
    if (op == OP_READ)
      chk("link read", {16'h0000, v}, {16'h0000, d});
    @(posedge clk);
  endtask
  task automatic pins(input logic a, input logic b, input logic i);
    repeat (3) @(posedge clk);
    chk("pins", {pin_a, pin_b, irq}, {a, b, i});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #400_000;
    err_total++;
    wrap_up;
  end
  // ==========
  // main sequence
  initial
  begin
    {resetn, psel, penable, pwrite, serial_mgmt_disable_strap} = 5'b0_0000;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    chk("data drive", {mgmt_data_line_first_oe, mgmt_data_line_second_oe}, 0);
    pins(1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(ADDR_CONFIG, CONFIG_RESET);
    rchk(ADDR_IRQ_STATUS, IRQ_ST_RESET);
    rchk(ADDR_IRQ_MASK, IRQ_MASK_RESET);
    foreach (ROWS[k])
    begin
      apb(1'b1, ROWS[k].a, ROWS[k].d);
      apb(1'b0, ROWS[k].a, 32'h0000_0000);
      chk("slverr", e, ROWS[k].e);
      if (!ROWS[k].e)
        chk("register", q, ROWS[k].x);
    end
    $display("register table done");
    lf(0, OP_WRITE, 5, 3, 16'hA5C3);
    rchk(ADDR_IRQ_STATUS, 32'h0000_0004);
    lf(0, OP_READ, 5, 3, 16'hA5C3);
    lf(1, OP_READ, 5, 3, 16'hFFFF);
    lf(0, OP_WRITE, 6, IRQ_EN_REG, 16'h0002);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_000F);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0003);
    apb(1'b1, ADDR_EVENT, 32'h0000_0040);
    pins(1'b0, 1'b1, 1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
    pins(1'b1, 1'b1, 1'b0);
    $display("single section done");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0001);
    lf(0, OP_READ, 5, 3, 16'hFFFF);
    lf(1, OP_READ, 5, 3, 16'hA5C3);
    lf(0, OP_WRITE, 2, 4, 16'h0F0F);
    lf(1, OP_WRITE, 2, 4, 16'h1111);
    lf(0, OP_READ, 2, 4, 16'h0F0F);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_000F);
    apb(1'b1, ADDR_EVENT, 32'h0000_0040);
    pins(1'b1, 1'b0, 1'b1);
    apb(1'b1, ADDR_EVENT, 32'h0000_0002);
    rchk(ADDR_IRQ_STATUS, 32'h0000_0002);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
    pins(1'b1, 1'b0, 1'b0);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0002);
    pins(1'b1, 1'b1, 1'b0);
    $display("split section done");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0003);
    lf(1, OP_READ, 5, 3, 16'hFFFF);
    apb(1'b1, ADDR_EVENT, 32'h0000_0040);
    pins(1'b1, 1'b1, 1'b0);
    apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_000F);
    lf(0, OP_WRITE, 5, 0, 16'h00AA);
    lf(0, OP_READ, 5, 0, 16'h00AA);
    $display("power-down and defaults done");
    fork
      u_mdio_master.frame(OP_READ, 5'd5, 5'd3, 16'h0000, dump);
    join_none
    repeat (850) @(posedge clk);
    chk("drive before reset", mgmt_data_line_first_oe, 1);
    resetn <= 1'b0;
    serial_mgmt_disable_strap <= 1'b1;
    repeat (2) @(posedge clk);
    chk("drive in reset", mgmt_data_line_first_oe, 0);
    resetn <= 1'b1;
    wait fork;
    @(posedge clk);
    lf(0, OP_READ, 5, 3, 16'hFFFF);
    apb(1'b0, ADDR_MGMT_STATUS, 32'h0000_0000);
    chk("disabled flag", q[0], 1);
    $display("strap and reset done");
    wrap_up;
  end
endmodule
bind phy_mgmt_serial_port mgmt_port_sva u_mgmt_port_sva (.clk, .resetn, .psel, .penable, .pready, .pslverr,
  .mgmt_clock_first, .mgmt_data_line_first_out, .mgmt_data_line_first_oe, .mgmt_data_line_second_oe,
  .serial_mgmt_disable_strap, .status_irq_n_first_out, .status_irq_n_first_oe, .status_irq_n_second_out,
  .status_irq_n_second_oe, .irq);
